// file: xsd_pkg.sv
package xsd_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned PC_W = 21;
   localparam int unsigned PCLAT_W = 13;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_WORK = 8'h08;
   localparam logic [7:0] OFF_BANK = 8'h0c;
   localparam logic [7:0] OFF_PTR0 = 8'h10;
   localparam logic [7:0] OFF_PTR1 = 8'h14;
   localparam logic [7:0] OFF_PTR2 = 8'h18;
   localparam logic [7:0] OFF_PC = 8'h1c;
   localparam logic [7:0] OFF_STACK = 8'h20;
   localparam logic [7:0] OFF_PCLAT = 8'h24;
   localparam logic [7:0] OFF_INFO = 8'h28;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_EXT_BIT = 0;
   localparam int unsigned CTRL_RUN_BIT = 1;
   localparam int unsigned ST_Z_BIT = 0;
   localparam int unsigned ST_N_BIT = 1;
   localparam int unsigned D_BIT = 9;
   localparam int unsigned A_BIT = 8;
   localparam int unsigned MOVS_IDX_BIT = 7;
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic [11:0] PTR_RST = 12'h000;
   localparam logic [20:0] PC_RST = 21'h000000;
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [15:0] WORD_RST = 16'hffff;

   // ----------------------------------------------------------------
   // opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OPC_XORL = 8'h0a;
   localparam logic [5:0] OPC_XORF = 6'h06;
   localparam logic [6:0] OPC_TST = 7'h33;
   localparam logic [7:0] OPC_ADDP = 8'he8;
   localparam logic [7:0] OPC_SUBP = 8'he9;
   localparam logic [7:0] OPC_PUSH_LITERAL_STACK = 8'hea;
   localparam logic [7:0] OPC_MOVS = 8'heb;
   localparam logic [15:0] OPC_CALL_VIA_WORK_REG = 16'h0014;
   localparam logic [3:0] OPC_MOVFF = 4'hc;
   localparam logic [6:0] OPC_CALL = 7'h76;
   localparam logic [7:0] OPC_GOTO = 8'hef;
   localparam logic [7:0] OPC_LFSR = 8'hee;
   localparam logic [1:0] RET_SEL = 2'h3;
   localparam logic [1:0] STACK_PTR = 2'h2;

   // ----------------------------------------------------------------
   // addressing
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_LIMIT = 8'h5f;
   localparam logic [7:0] ACC_SPLIT = 8'h60;
   localparam logic [3:0] ACC_LO_BANK = 4'h0;
   localparam logic [3:0] ACC_HI_BANK = 4'hf;

   typedef enum logic [3:0] {
      PH_Q1 = 4'h1,
      PH_Q2 = 4'h2,
      PH_Q3 = 4'h4,
      PH_Q4 = 4'h8
   } xsd_phase_type;

   typedef enum logic [3:0] {
      OP_NOP, OP_TST, OP_XORL, OP_XORF, OP_ADDP, OP_ADDRET,
      OP_SUBP, OP_SUBRET, OP_CALL_VIA_WORK_REG, OP_MOVS1, OP_MOVS2, OP_PUSH_LITERAL_STACK
   } xsd_op_type;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic we;
   } xsd_dmem_req_type;
endpackage : xsd_pkg

// file: xsd_addr_resolve.sv
`timescale 1ns/10ps
module xsd_addr_resolve (
   input wire logic [7:0] f_field, // register operand
   input wire logic a_bit, // bank-select operand bit
   input wire logic ext_en, // extended set enabled
   input wire logic [3:0] bank, // bank select register
   input wire logic [11:0] ptr_two, // pointer two
   output logic [11:0] addr, // resolved data address
   output logic indexed // indexed literal offset in use
);
   always_comb begin
      indexed = !a_bit && ext_en
         && (f_field <= xsd_pkg::IDX_LIMIT);
      if (indexed) begin
         addr = ptr_two + {4'h0, f_field};
      end else if (a_bit) begin
         addr = {bank, f_field};
      end else if (f_field < xsd_pkg::ACC_SPLIT) begin
         addr = {xsd_pkg::ACC_LO_BANK, f_field};
      end else begin
         addr = {xsd_pkg::ACC_HI_BANK, f_field};
      end
   end
endmodule : xsd_addr_resolve

// file: xsd_core.sv
`timescale 1ns/10ps
// Behaviour
// - zero test discards next word, flags untouched
// - skipped two-word instruction costs three cycles
// - bank bit picks access bank or bank select
// - extended, access, operand up to 95: indexed
// - literal xor into working register, N and Z
// - register xor, destination bit, one cycle
// - extended features only with configuration bit
// - eight extra pointer-literal instructions when enabled
// - add to pointer two then return, two cycles
// - subtract literal from selected pointer, one cycle
// - subtract from pointer two then return, two cycles
// - call via working register, two cycles
// - two-word memory moves, indexed or direct destination
// - push literal at pointer two, then decrement
// - add literal to selected pointer, one cycle
// - return loads stack top, second cycle idle
module xsd_core (
   input wire logic core_clk, // core clock, 50 MHz
   input wire logic rstn, // async reset, active low
   input wire logic [7:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   output logic [20:0] prog_addr, // program fetch address
   output logic prog_fetch, // fetch strobe in Q4
   input wire logic [15:0] prog_data, // fetched word
   output xsd_pkg::xsd_dmem_req_type dmem_req, // data memory request
   input wire logic [7:0] dmem_rdata // data memory read data
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   xsd_pkg::xsd_phase_type phase_reg;
   xsd_pkg::xsd_op_type op_reg;
   xsd_pkg::xsd_op_type op_next;
   logic active_reg;
   logic [15:0] ir_reg;
   logic [15:0] prefetch_reg;
   logic discard_reg;
   logic mov_pend_reg;
   logic mov_idx_reg;
   logic [7:0] work_reg;
   logic [7:0] data_reg;
   logic [3:0] bank_reg;
   logic [11:0] ptr_reg [3];
   logic n_reg;
   logic z_reg;
   logic [20:0] pc_reg;
   logic [20:0] stack_reg;
   logic [12:0] pclat_reg;
   logic ext_reg;
   logic run_reg;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic wr_en;
   logic [11:0] res_addr;
   logic res_indexed;
   logic [11:0] rd_addr;
   logic two_word_pf;
   logic [7:0] xor_lit;
   logic [7:0] xor_reg;
   logic [7:0] result;
   logic flags_upd;
   logic pc_from_stack;
   logic flush;
   logic end_q1;
   logic end_q4;
   logic [1:0] adj_sel;
   logic adj_on;
   logic adj_sub;
   logic [11:0] adj_val;

   assign end_q1 = (phase_reg == xsd_pkg::PH_Q1);
   assign end_q4 = active_reg && (phase_reg == xsd_pkg::PH_Q4);

   // ----------------------------------------------------------------
   // apb slave, zero wait states
   // ----------------------------------------------------------------
   assign pready = 1'b1;
   assign pslverr = psel && penable && !rd_hit;
   assign wr_en = psel && penable && pwrite && rd_hit;

   always_comb begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      case (paddr)
         xsd_pkg::OFF_CTRL: begin
            rd_mux[xsd_pkg::CTRL_EXT_BIT] = ext_reg;
            rd_mux[xsd_pkg::CTRL_RUN_BIT] = run_reg;
         end
         xsd_pkg::OFF_STATUS: begin
            rd_mux[xsd_pkg::ST_Z_BIT] = z_reg;
            rd_mux[xsd_pkg::ST_N_BIT] = n_reg;
         end
         xsd_pkg::OFF_WORK: rd_mux[7:0] = work_reg;
         xsd_pkg::OFF_BANK: rd_mux[3:0] = bank_reg;
         xsd_pkg::OFF_PTR0: rd_mux[11:0] = ptr_reg[0];
         xsd_pkg::OFF_PTR1: rd_mux[11:0] = ptr_reg[1];
         xsd_pkg::OFF_PTR2: rd_mux[11:0] = ptr_reg[2];
         xsd_pkg::OFF_PC: rd_mux[20:0] = pc_reg;
         xsd_pkg::OFF_STACK: rd_mux[20:0] = stack_reg;
         xsd_pkg::OFF_PCLAT: rd_mux[12:0] = pclat_reg;
         xsd_pkg::OFF_INFO: begin
            rd_mux[3:0] = phase_reg;
            rd_mux[4] = active_reg;
            rd_mux[5] = discard_reg;
            rd_mux[6] = mov_pend_reg;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // read data is caught in the setup cycle so the access phase can end
   // at once without a combinational path to prdata
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && (!pwrite || !rd_hit)) begin
         prdata <= rd_mux;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ext_reg <= 1'b0;
         run_reg <= 1'b0;
      end else if (wr_en && paddr == xsd_pkg::OFF_CTRL) begin
         ext_reg <= pwdata[xsd_pkg::CTRL_EXT_BIT];
         run_reg <= pwdata[xsd_pkg::CTRL_RUN_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bank_reg <= xsd_pkg::BANK_RST;
         pclat_reg <= '0;
      end else if (wr_en) begin
         if (paddr == xsd_pkg::OFF_BANK) begin
            bank_reg <= pwdata[3:0];
         end
         if (paddr == xsd_pkg::OFF_PCLAT) begin
            pclat_reg <= pwdata[12:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // phase sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         phase_reg <= xsd_pkg::PH_Q1;
      end else begin
         case (phase_reg)
            xsd_pkg::PH_Q1: phase_reg <= xsd_pkg::PH_Q2;
            xsd_pkg::PH_Q2: phase_reg <= xsd_pkg::PH_Q3;
            xsd_pkg::PH_Q3: phase_reg <= xsd_pkg::PH_Q4;
            xsd_pkg::PH_Q4: phase_reg <= xsd_pkg::PH_Q1;
            default: phase_reg <= xsd_pkg::PH_Q1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // decode of the prefetched word
   // ----------------------------------------------------------------
   assign two_word_pf = (ext_reg && prefetch_reg[15:8] == xsd_pkg::OPC_MOVS)
      || prefetch_reg[15:12] == xsd_pkg::OPC_MOVFF
      || prefetch_reg[15:9] == xsd_pkg::OPC_CALL
      || prefetch_reg[15:8] == xsd_pkg::OPC_GOTO
      || prefetch_reg[15:8] == xsd_pkg::OPC_LFSR;

   always_comb begin
      op_next = xsd_pkg::OP_NOP;
      if (discard_reg) begin
         op_next = xsd_pkg::OP_NOP;
      end else if (mov_pend_reg) begin
         op_next = xsd_pkg::OP_MOVS2;
      end else if (prefetch_reg[15:8] == xsd_pkg::OPC_XORL) begin
         op_next = xsd_pkg::OP_XORL;
      end else if (prefetch_reg[15:10] == xsd_pkg::OPC_XORF) begin
         op_next = xsd_pkg::OP_XORF;
      end else if (prefetch_reg[15:9] == xsd_pkg::OPC_TST) begin
         op_next = xsd_pkg::OP_TST;
      end else if (ext_reg) begin
         if (prefetch_reg == xsd_pkg::OPC_CALL_VIA_WORK_REG) begin
            op_next = xsd_pkg::OP_CALL_VIA_WORK_REG;
         end else if (prefetch_reg[15:8] == xsd_pkg::OPC_ADDP) begin
            op_next = (prefetch_reg[7:6] == xsd_pkg::RET_SEL) ?
               xsd_pkg::OP_ADDRET : xsd_pkg::OP_ADDP;
         end else if (prefetch_reg[15:8] == xsd_pkg::OPC_SUBP) begin
            op_next = (prefetch_reg[7:6] == xsd_pkg::RET_SEL) ?
               xsd_pkg::OP_SUBRET : xsd_pkg::OP_SUBP;
         end else if (prefetch_reg[15:8] == xsd_pkg::OPC_PUSH_LITERAL_STACK) begin
            op_next = xsd_pkg::OP_PUSH_LITERAL_STACK;
         end else if (prefetch_reg[15:8] == xsd_pkg::OPC_MOVS) begin
            op_next = xsd_pkg::OP_MOVS1;
         end
      end
   end

   xsd_addr_resolve u_resolve (
      .f_field(prefetch_reg[7:0]),
      .a_bit(prefetch_reg[xsd_pkg::A_BIT]),
      .ext_en(ext_reg),
      .bank(bank_reg),
      .ptr_two(ptr_reg[xsd_pkg::STACK_PTR]),
      .addr(res_addr),
      .indexed(res_indexed)
   );

   always_comb begin
      case (op_next)
         xsd_pkg::OP_MOVS1:
            rd_addr = ptr_reg[xsd_pkg::STACK_PTR]
               + {5'h00, prefetch_reg[6:0]};
         xsd_pkg::OP_MOVS2:
            rd_addr = mov_idx_reg ? (ptr_reg[xsd_pkg::STACK_PTR]
               + {5'h00, prefetch_reg[6:0]})
               : prefetch_reg[11:0];
         xsd_pkg::OP_PUSH_LITERAL_STACK: rd_addr = ptr_reg[xsd_pkg::STACK_PTR];
         default: rd_addr = res_addr;
      endcase
   end

   // ----------------------------------------------------------------
   // instruction register and skip bookkeeping
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         active_reg <= 1'b0;
         ir_reg <= xsd_pkg::WORD_RST;
         op_reg <= xsd_pkg::OP_NOP;
      end else if (end_q1) begin
         active_reg <= run_reg;
         ir_reg <= prefetch_reg;
         op_reg <= run_reg ? op_next : xsd_pkg::OP_NOP;
      end
   end

   assign pc_from_stack = (op_reg == xsd_pkg::OP_ADDRET)
      || (op_reg == xsd_pkg::OP_SUBRET);
   assign flush = (op_reg == xsd_pkg::OP_TST && data_reg == 8'h00)
      || pc_from_stack || op_reg == xsd_pkg::OP_CALL_VIA_WORK_REG;

   // the word behind a skipped two-word opcode is dropped as well; a jump
   // only ever fetches one stale word, whatever it looks like
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         discard_reg <= 1'b0;
      end else if (end_q1 && run_reg && discard_reg) begin
         discard_reg <= two_word_pf
            && op_reg == xsd_pkg::OP_TST;
      end else if (end_q4 && flush) begin
         discard_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mov_pend_reg <= 1'b0;
         mov_idx_reg <= 1'b0;
      end else if (end_q1 && run_reg) begin
         mov_pend_reg <= 1'b0;
      end else if (end_q4 && op_reg == xsd_pkg::OP_MOVS1) begin
         mov_pend_reg <= 1'b1;
         mov_idx_reg <= ir_reg[xsd_pkg::MOVS_IDX_BIT];
      end
   end

   // ----------------------------------------------------------------
   // data memory: address in Q2, read in Q2, write during Q4
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         data_reg <= 8'h00;
      end else if (active_reg && phase_reg == xsd_pkg::PH_Q2
         && op_reg != xsd_pkg::OP_MOVS2) begin
         data_reg <= dmem_rdata;
      end
   end

   assign xor_lit = work_reg ^ ir_reg[7:0];
   assign xor_reg = work_reg ^ data_reg;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dmem_req <= '0;
      end else begin
         dmem_req.we <= 1'b0;
         if (end_q1) begin
            dmem_req.addr <= rd_addr;
         end
         if (active_reg && phase_reg == xsd_pkg::PH_Q3) begin
            case (op_reg)
               xsd_pkg::OP_XORF: begin
                  dmem_req.we <= ir_reg[xsd_pkg::D_BIT];
                  dmem_req.wdata <= xor_reg;
               end
               xsd_pkg::OP_MOVS2: begin
                  dmem_req.we <= 1'b1;
                  dmem_req.wdata <= data_reg;
               end
               xsd_pkg::OP_PUSH_LITERAL_STACK: begin
                  dmem_req.we <= 1'b1;
                  dmem_req.wdata <= ir_reg[7:0];
               end
               default: dmem_req.we <= 1'b0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // working register and flags
   // ----------------------------------------------------------------
   assign result = (op_reg == xsd_pkg::OP_XORL) ? xor_lit : xor_reg;
   assign flags_upd = (op_reg == xsd_pkg::OP_XORL)
      || (op_reg == xsd_pkg::OP_XORF);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         work_reg <= xsd_pkg::WORK_RST;
      end else if (end_q4 && op_reg == xsd_pkg::OP_XORL) begin
         work_reg <= xor_lit;
      end else if (end_q4 && op_reg == xsd_pkg::OP_XORF
         && !ir_reg[xsd_pkg::D_BIT]) begin
         work_reg <= xor_reg;
      end else if (wr_en && paddr == xsd_pkg::OFF_WORK) begin
         work_reg <= pwdata[7:0];
      end
   end

   // skip, pointer and call forms leave the flags alone
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         n_reg <= 1'b0;
         z_reg <= 1'b0;
      end else if (end_q4 && flags_upd) begin
         n_reg <= result[7];
         z_reg <= (result == 8'h00);
      end else if (wr_en && paddr == xsd_pkg::OFF_STATUS) begin
         n_reg <= pwdata[xsd_pkg::ST_N_BIT];
         z_reg <= pwdata[xsd_pkg::ST_Z_BIT];
      end
   end

   // ----------------------------------------------------------------
   // pointers
   // ----------------------------------------------------------------
   always_comb begin
      adj_sel = ir_reg[7:6];
      adj_on = 1'b1;
      adj_sub = 1'b0;
      adj_val = {6'h00, ir_reg[5:0]};
      case (op_reg)
         xsd_pkg::OP_ADDP: adj_on = 1'b1;
         xsd_pkg::OP_SUBP: adj_sub = 1'b1;
         xsd_pkg::OP_ADDRET: adj_sel = xsd_pkg::STACK_PTR;
         xsd_pkg::OP_SUBRET: begin
            adj_sel = xsd_pkg::STACK_PTR;
            adj_sub = 1'b1;
         end
         xsd_pkg::OP_PUSH_LITERAL_STACK: begin
            adj_sel = xsd_pkg::STACK_PTR;
            adj_sub = 1'b1;
            adj_val = 12'h001;
         end
         default: adj_on = 1'b0;
      endcase
   end

   for (genvar i = 0; i < 3; i++) begin : g_ptr
      localparam logic [1:0] SEL = 2'(i);
      localparam logic [7:0] OFF = xsd_pkg::OFF_PTR0 + 8'(4 * i);
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            ptr_reg[i] <= xsd_pkg::PTR_RST;
         end else if (end_q4 && adj_on && adj_sel == SEL) begin
            ptr_reg[i] <= adj_sub ? ptr_reg[i] - adj_val
               : ptr_reg[i] + adj_val;
         end else if (wr_en && paddr == OFF) begin
            ptr_reg[i] <= pwdata[11:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // fetch, program counter and return stack top
   // ----------------------------------------------------------------
   assign prog_addr = pc_reg;
   assign prog_fetch = end_q4;

   // the word fetched in the same Q4 as a jump is stale and is flushed
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prefetch_reg <= xsd_pkg::WORD_RST;
         pc_reg <= xsd_pkg::PC_RST;
      end else if (end_q4) begin
         prefetch_reg <= prog_data;
         if (pc_from_stack) begin
            pc_reg <= stack_reg;
         end else if (op_reg == xsd_pkg::OP_CALL_VIA_WORK_REG) begin
            pc_reg <= {pclat_reg, work_reg};
         end else begin
            pc_reg <= pc_reg + xsd_pkg::PC_STEP;
         end
      end else if (wr_en && paddr == xsd_pkg::OFF_PC) begin
         pc_reg <= pwdata[20:0];
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         stack_reg <= xsd_pkg::PC_RST;
      end else if (end_q4 && op_reg == xsd_pkg::OP_CALL_VIA_WORK_REG) begin
         stack_reg <= pc_reg;
      end else if (wr_en && paddr == xsd_pkg::OFF_STACK) begin
         stack_reg <= pwdata[20:0];
      end
   end
endmodule : xsd_core

// file: xsd_mem_model.sv
`timescale 1ns/10ps
module xsd_mem_model (
   input wire logic core_clk, // core clock
   input wire logic [20:0] prog_addr, // fetch address
   input wire logic prog_fetch, // fetch strobe
   output logic [15:0] prog_data, // fetched word
   input wire xsd_pkg::xsd_dmem_req_type dmem_req, // data request
   output logic [7:0] dmem_rdata // data read byte
);
   logic [15:0] pmem [0:255] = '{default: 16'hffff};
   logic [7:0] dmem [0:4095] = '{default: 8'h00};
   // word is only promised under the strobe, so scramble it elsewhere
   assign prog_data = prog_fetch ? pmem[prog_addr[8:1]]
                                 : ~pmem[prog_addr[8:1]];
   assign dmem_rdata = dmem[dmem_req.addr];
   always @(posedge core_clk) begin
      if (dmem_req.we) begin
         dmem[dmem_req.addr] <= dmem_req.wdata;
      end
   end
endmodule : xsd_mem_model

// file: xsd_core_properties.sv
`timescale 1ns/10ps
module xsd_core_properties (
   input wire logic core_clk, // core clock
   input wire logic rstn, // reset, active low
   input wire logic [7:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic [20:0] prog_addr, // fetch address
   input wire logic prog_fetch, // fetch strobe
   input wire logic [15:0] prog_data, // fetched word
   input wire xsd_pkg::xsd_dmem_req_type dmem_req, // data request
   input wire logic [7:0] dmem_rdata // data read byte
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   a_fetch_spacing: assert property (
      prog_fetch |=> !prog_fetch [*3])
      else $error("fetch strobes closer than one instruction cycle");
   a_write_spacing: assert property (
      dmem_req.we |=> !dmem_req.we [*3])
      else $error("two data writes in one instruction cycle");
   a_write_in_q4: assert property (
      dmem_req.we |-> prog_fetch)
      else $error("data write outside the last phase");
   a_addr_hold: assert property (
      $changed(dmem_req.addr) |=> $stable(dmem_req.addr) [*3])
      else $error("data address moved inside an instruction cycle");
   a_pc_hold: assert property (
      !prog_fetch && !(psel && penable && pwrite) |=> $stable(prog_addr))
      else $error("fetch address moved between fetches");
   a_ready_now: assert property (
      psel && penable |-> pready)
      else $error("bus access not answered at once");
   a_err_idle: assert property (
      !(psel && penable) |-> !pslverr)
      else $error("bus error outside an access");
   a_err_unmapped: assert property (
      psel && penable && paddr > 8'h28 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (
      psel && penable && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
endmodule : xsd_core_properties
bind xsd_core xsd_core_properties xsd_core_properties_i (.core_clk, .rstn,
   .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
   .prog_addr, .prog_fetch, .prog_data, .dmem_req, .dmem_rdata);

// file: cpu_xor_skip_ext_decode_test.sv
`timescale 1ns/10ps
module cpu_xor_skip_ext_decode_test;
   logic core_clk = 1'h0;
   logic rstn = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rdat;
   logic pready;
   logic pslverr;
   logic rerr;
   logic [20:0] prog_addr;
   logic prog_fetch;
   logic [15:0] prog_data;
   xsd_pkg::xsd_dmem_req_type dmem_req;
   logic [7:0] dmem_rdata;
   logic [31:0] seed = 32'h4dc5;
   logic [7:0] w0, k1, m, q, s, t;
   logic [11:0] p, r0, r1;
   int err_total = 0;
   int compares = 0;
   always #10 core_clk = ~core_clk;
   xsd_core xsd_core_i (.core_clk, .rstn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .prog_addr, .prog_fetch,
      .prog_data, .dmem_req, .dmem_rdata);
   xsd_mem_model xsd_mem_model_i (.core_clk, .prog_addr, .prog_fetch,
      .prog_data, .dmem_req, .dmem_rdata);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function logic [7:0] rb();
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
      end
      return seed[7:0];
   endfunction : rb
   function automatic logic [31:0] flags(input logic [7:0] w);
      return {30'h0, w[7], w == 8'h00};
   endfunction : flags
   function automatic logic [31:0] dm(input int a);
      return {24'h0, xsd_mem_model_i.dmem[a]};
   endfunction : dm
   task close_out;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'h1;
      @(posedge core_clk);
      penable <= 1'h1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         err_total++;
         close_out();
      end
      @(posedge core_clk);
   endtask : apb
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'h0, 32'h0);
      chk(rdat, exp);
   endtask : rd
   task wait_pc(input logic [20:0] a);
      for (int n = 0; n < 400 && prog_addr !== a; n++) begin
         @(posedge core_clk);
      end
      if (prog_addr !== a) begin
         err_total++;
         close_out();
      end
   endtask : wait_pc
   task pw(input int a, input logic [15:0] d);
      xsd_mem_model_i.pmem[a] = d;
   endtask : pw
   initial begin
      w0 = rb();
      k1 = rb();
      m = rb();
      q = rb();
      s = rb();
      t = rb();
      p = {4'h1, t};
      r0 = {4'h3, rb()};
      r1 = {4'h4, rb()};
      repeat (12) @(posedge core_clk);
      rstn <= 1'h1;
      @(posedge core_clk);
      rd(xsd_pkg::OFF_WORK, 32'h0);
      xsd_mem_model_i.dmem[12'hf80] = m;
      xsd_mem_model_i.dmem[{2'h2, t[1:0], 8'h20}] = q;
      xsd_mem_model_i.dmem[p + 12'h1] = s;
      xsd_mem_model_i.dmem[12'h010] = 8'h01;
      pw(0, {8'h0a, k1});
      pw(1, 16'h1a80);
      pw(2, 16'h6681);
      pw(3, 16'h0aff);
      pw(4, 16'h6610);
      pw(5, 16'heb85);
      pw(6, 16'hf001);
      pw(7, 16'hea5a);
      pw(8, 16'he83f);
      pw(9, 16'he941);
      pw(10, 16'h1920);
      pw(11, 16'heb02);
      pw(12, 16'hf345);
      pw(13, 16'he9c3);
      pw(64, {8'h0a, w0 ^ k1 ^ q ^ 8'h80});
      pw(65, 16'h0014);
      pw(66, 16'heb80);
      pw(67, 16'hf003);
      pw(192, 16'he8c5);
      pw(80, 16'hea77);
      pw(81, 16'he801);
      pw(82, 16'h6610);
      pw(83, 16'h0a0f);
      apb(xsd_pkg::OFF_CTRL, 1'h1, 32'h1);
      apb(xsd_pkg::OFF_WORK, 1'h1, {24'h0, w0});
      apb(xsd_pkg::OFF_BANK, 1'h1, {28'h0, 2'h2, t[1:0]});
      apb(xsd_pkg::OFF_PTR0, 1'h1, {20'h0, r0});
      apb(xsd_pkg::OFF_PTR1, 1'h1, {20'h0, r1});
      apb(xsd_pkg::OFF_PTR2, 1'h1, {20'h0, p});
      apb(xsd_pkg::OFF_STACK, 1'h1, 32'h80);
      apb(xsd_pkg::OFF_PCLAT, 1'h1, 32'h1);
      apb(xsd_pkg::OFF_CTRL, 1'h1, 32'h3);
      wait_pc(21'h88);
      apb(xsd_pkg::OFF_CTRL, 1'h1, 32'h0);
      rd(xsd_pkg::OFF_WORK, 32'h80);
      rd(xsd_pkg::OFF_STATUS, flags(8'h80));
      rd(xsd_pkg::OFF_PTR2, {20'h0, p + 12'h1});
      rd(xsd_pkg::OFF_PTR0, {20'h0, r0 + 12'h3f});
      rd(xsd_pkg::OFF_PTR1, {20'h0, r1 - 12'h1});
      rd(xsd_pkg::OFF_STACK, 32'h84);
      chk(dm(12'hf80), {24'h0, m ^ w0 ^ k1});
      chk(dm(p), 32'h5a);
      chk(dm(12'h345), {24'h0, s});
      chk(dm(p + 12'h4), {24'h0, s});
      apb(xsd_pkg::OFF_PC, 1'h1, 32'ha0);
      apb(xsd_pkg::OFF_CTRL, 1'h1, 32'h2);
      wait_pc(21'hac);
      apb(xsd_pkg::OFF_CTRL, 1'h1, 32'h0);
      rd(xsd_pkg::OFF_WORK, 32'h8f);
      rd(xsd_pkg::OFF_PTR2, {20'h0, p + 12'h1});
      rd(xsd_pkg::OFF_PTR0, {20'h0, r0 + 12'h3f});
      chk(dm(p + 12'h1), {24'h0, s});
      rd(8'h3c, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      close_out();
   end
endmodule : cpu_xor_skip_ext_decode_test
